/* File: logic/tcc_pkg.sv */
// constants, types and field layout of the two-channel capture/compare timer
`default_nettype none

package tcc_pkg;

    // register byte addresses
    localparam logic [15:0] TCC_ADDR_STATUS  = 16'h0040;
    localparam logic [15:0] TCC_ADDR_CNT_HI  = 16'h0041;
    localparam logic [15:0] TCC_ADDR_CNT_LO  = 16'h0042;
    localparam logic [15:0] TCC_ADDR_MOD_HI  = 16'h0043;
    localparam logic [15:0] TCC_ADDR_MOD_LO  = 16'h0044;
    localparam logic [15:0] TCC_ADDR_C0_CTRL = 16'h0045;
    localparam logic [15:0] TCC_ADDR_C0_HI   = 16'h0046;
    localparam logic [15:0] TCC_ADDR_C0_LO   = 16'h0047;
    localparam logic [15:0] TCC_ADDR_C1_CTRL = 16'h0048;
    localparam logic [15:0] TCC_ADDR_C1_HI   = 16'h0049;
    localparam logic [15:0] TCC_ADDR_C1_LO   = 16'h004A;
    // address step between the two channel blocks
    localparam logic [15:0] TCC_CHAN_STRIDE  = 16'h0003;

    // timer status/control field positions
    localparam int TCC_BIT_OVF_FLAG  = 7;
    localparam int TCC_BIT_OVF_IE    = 6;
    localparam int TCC_BIT_HALT      = 5;
    localparam int TCC_BIT_CLEAR     = 4;
    // channel status/control: event flag position
    localparam int TCC_BIT_EVT_FLAG  = 7;

    // clock divider select code that picks the external pin
    localparam logic [2:0]  TCC_SEL_EXT_PIN  = 3'h7;
    // reset values
    localparam logic        TCC_HALT_RESET   = 1'b1;
    localparam logic [2:0]  TCC_DIV_RESET    = 3'h0;
    localparam logic [15:0] TCC_MOD_RESET    = 16'hFFFF;
    // bus cycles from pin edge to captured value
    localparam int          TCC_CAPTURE_LAT  = 2;
    localparam logic [7:0]  TCC_UNMAPPED     = 8'h00;

    // channel control bits below the event flag, bit 6 down to bit 0
    typedef struct packed {
        logic irq_enable;
        logic pair_link_select;
        logic mode_select;
        logic edge_select_upper;
        logic edge_select_lower;
        logic overflow_toggle;
        logic full_duty;
    } tcc_chan_ctrl_s;

    // one capture in flight: hit marker and counter snapshot
    typedef struct packed {
        logic        hit;
        logic [15:0] count;
    } tcc_cap_s;

endpackage : tcc_pkg

`default_nettype wire

/* File: logic/tcc_timer.sv */
// two-channel capture/compare timer with byte-wide register port
`default_nettype none

module tcc_timer (
    input  wire logic        clk_sys,             // bus clock, 10 MHz
    input  wire logic        sys_rst,             // async reset, active high
    input  wire logic [15:0] bus_addr,            // register byte address
    input  wire logic [7:0]  bus_wdata,           // write data
    input  wire logic        bus_wr,              // write strobe
    input  wire logic        bus_rd,              // read strobe
    output logic      [7:0]  bus_rdata,           // read data, cycle after strobe
    input  wire logic        ext_timer_clock_pin, // external counter clock
    input  wire logic        chan0_pin_in,        // channel 0 pin level
    output logic             chan0_pin_out,       // channel 0 pin drive value
    output logic             chan0_pin_oe_n,      // low while channel 0 drives
    input  wire logic        chan1_pin_in,        // channel 1 pin level
    output logic             chan1_pin_out,       // channel 1 pin drive value
    output logic             chan1_pin_oe_n,      // low while channel 1 drives
    output logic             irq_req              // interrupt request, level
);
    import tcc_pkg::*;

    // a channel is in compare mode when either mode bit is set
    function automatic logic is_compare(input tcc_chan_ctrl_s c);
        return c.mode_select | c.pair_link_select;
    endfunction

    // edge qualifier for capture: 01 rising, 10 falling, 11 either
    function automatic logic edge_hit(input tcc_chan_ctrl_s c, input logic prev,
                                      input logic cur);
        return (c.edge_select_lower & ~prev & cur) | (c.edge_select_upper & prev & ~cur);
    endfunction

    // pin value after a compare: 01 toggle, 10 clear, 11 set
    function automatic logic match_action(input tcc_chan_ctrl_s c, input logic pin);
        logic r;
        r = pin;
        if (c.edge_select_upper && c.edge_select_lower) begin
            r = 1'b1;
        end else if (c.edge_select_upper) begin
            r = 1'b0;
        end else if (c.edge_select_lower) begin
            r = ~pin;
        end
        return r;
    endfunction

    // ---------------- register state ----------------
    logic           ovf_flag;        // overflow flag
    logic           ovf_armed;       // flag seen set by a status read
    logic           ovf_ie;          // overflow interrupt enable
    logic           halt;            // counter halt
    logic [2:0]     div_sel;         // clock divider select
    logic [15:0]    modulo;          // terminal count
    logic [15:0]    count;           // timebase counter
    logic [6:0]     presc;           // prescaler chain
    logic           ext_prev;        // external clock, last sample
    logic           tick_d;          // counter advanced last cycle
    logic [7:0]     cnt_lo_latch;    // low byte held by high-byte read
    logic           cnt_locked;      // low byte read returns latch
    logic           last_written;    // pair register written last
    logic           active_sel;      // pair register in control

    tcc_chan_ctrl_s ctrl   [2];      // channel control fields
    logic           evt    [2];      // channel event flags
    logic           armed  [2];      // event flag seen set by a read
    logic [15:0]    value  [2];      // channel value registers
    logic [7:0]     hi_wr  [2];      // high byte awaiting low-byte write
    logic [7:0]     lo_lat [2];      // low byte held by high-byte read
    logic           locked [2];      // channel low read returns latch
    logic           pin_q  [2];      // compare output state
    logic           pin_prev [2];    // last pin sample for edge detection
    tcc_cap_s       cap_pipe [2][TCC_CAPTURE_LAT-1]; // captures in flight

    // ---------------- address decode ----------------
    wire wr_status  = bus_wr && (bus_addr == TCC_ADDR_STATUS);
    wire rd_status  = bus_rd && (bus_addr == TCC_ADDR_STATUS);
    wire rd_cnt_hi  = bus_rd && (bus_addr == TCC_ADDR_CNT_HI);
    wire rd_cnt_lo  = bus_rd && (bus_addr == TCC_ADDR_CNT_LO);
    wire wr_mod_hi  = bus_wr && (bus_addr == TCC_ADDR_MOD_HI);
    wire wr_mod_lo  = bus_wr && (bus_addr == TCC_ADDR_MOD_LO);

    // ---------------- prescaler and counter clock ----------------
    // divider outputs are one-cycle enables, never derived clocks
    wire [7:0] div_taps  = {presc & ~(presc - 7'h01), 1'b1};
    wire       ext_rise  = ext_timer_clock_pin & ~ext_prev;
    // select 0..6 divides by 1..64; the last code takes the pin
    wire       rate_en   = (div_sel == TCC_SEL_EXT_PIN) ? ext_rise : div_taps[div_sel];
    wire       clear_req = wr_status && bus_wdata[TCC_BIT_CLEAR];
    wire       tick      = rate_en && !halt && !clear_req;
    // with the default all-ones limit the counter runs its full range
    wire       at_limit  = (count == modulo);
    wire       overflow  = tick && at_limit;
    wire [15:0] next_count = at_limit ? 16'h0000 : count + 16'h0001;

    // prescaler, counter and their clear; reads never touch them
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            presc    <= 7'h00;
            count    <= 16'h0000;
            ext_prev <= 1'b0;
            tick_d   <= 1'b0;
        end else begin
            ext_prev <= ext_timer_clock_pin;
            tick_d   <= tick;
            if (clear_req) begin               // write-only clear bit
                presc <= 7'h00;
                count <= 16'h0000;
            end else begin
                presc <= presc + 7'h01;
                if (tick) begin
                    count <= next_count;
                end
            end
        end
    end

    // ---------------- timer status/control ----------------
    // overflow flag: setting wins over a clear in the same cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ovf_flag  <= 1'b0;
            ovf_armed <= 1'b0;
            ovf_ie    <= 1'b0;
            halt      <= TCC_HALT_RESET;
            div_sel   <= TCC_DIV_RESET;
        end else begin
            if (overflow) begin
                ovf_flag <= 1'b1;
            end else if (wr_status && ovf_armed && !bus_wdata[TCC_BIT_OVF_FLAG]) begin
                ovf_flag <= 1'b0;
            end
            // arming needs a read that saw the flag set
            if (rd_status && ovf_flag) begin
                ovf_armed <= 1'b1;
            end else if (wr_status || !ovf_flag) begin
                ovf_armed <= 1'b0;
            end
            if (wr_status) begin
                ovf_ie  <= bus_wdata[TCC_BIT_OVF_IE];
                halt    <= bus_wdata[TCC_BIT_HALT];
                div_sel <= bus_wdata[2:0];
            end
        end
    end

    // ---------------- coherent counter read ----------------
    // a high-byte read freezes the low byte until the low byte is read
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_lo_latch <= 8'h00;
            cnt_locked   <= 1'b0;
        end else if (rd_cnt_hi) begin
            cnt_lo_latch <= count[7:0];
            cnt_locked   <= 1'b1;
        end else if (rd_cnt_lo) begin
            cnt_locked   <= 1'b0;
        end
    end

    // modulo limit: no reset-time snapshot needed, constant reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            modulo <= TCC_MOD_RESET;
        end else if (wr_mod_hi) begin
            modulo[15:8] <= bus_wdata;
        end else if (wr_mod_lo) begin
            modulo[7:0] <= bus_wdata;
        end
    end

    // ---------------- pair link ----------------
    wire linked = ctrl[0].pair_link_select;
    wire [1:0] val_commit;   // low-byte write completed a channel value

    // the register written last takes over at the next overflow
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            last_written <= 1'b0;
            active_sel   <= 1'b0;
        end else begin
            if (val_commit[1]) begin
                last_written <= 1'b1;
            end else if (val_commit[0]) begin
                last_written <= 1'b0;
            end
            if (!linked) begin
                active_sel <= 1'b0;
            end else if (overflow) begin
                active_sel <= last_written;
            end
        end
    end

    // ---------------- channels ----------------
    wire [1:0] chan_irq;
    wire [7:0] chan_rd_ctrl [2];
    wire [7:0] chan_rd_hi   [2];
    wire [7:0] chan_rd_lo   [2];
    wire [1:0] chan_drive;

    for (genvar i = 0; i < 2; i++) begin : g_chan
        localparam logic [15:0] BASE = TCC_ADDR_C0_CTRL + TCC_CHAN_STRIDE * 16'(i);
        wire wr_ctrl = bus_wr && (bus_addr == BASE);
        wire rd_ctrl = bus_rd && (bus_addr == BASE);
        wire wr_hi   = bus_wr && (bus_addr == BASE + 16'h0001);
        wire rd_hi   = bus_rd && (bus_addr == BASE + 16'h0001);
        wire wr_lo   = bus_wr && (bus_addr == BASE + 16'h0002);
        wire rd_lo   = bus_rd && (bus_addr == BASE + 16'h0002);
        wire pin_in  = (i == 0) ? chan0_pin_in : chan1_pin_in;
        // channel 1 goes idle while paired; channel 0 then runs the pair
        wire idle    = (i == 1) && linked;
        wire cmp     = is_compare(ctrl[i]) && !idle;
        wire cap     = !is_compare(ctrl[i]) && !idle;
        wire hit     = cap && edge_hit(ctrl[i], pin_prev[i], pin_in);
        wire landed  = cap_pipe[i][TCC_CAPTURE_LAT-2].hit;
        // compare value: the active pair register when linked
        wire [15:0] cmp_val = (i == 0 && linked) ? value[active_sel] : value[i];
        // match is taken once, on the cycle after the counter moved
        wire match   = cmp && tick_d && (count == cmp_val);
        wire evt_set = landed || match;
        logic next_pin;

        assign val_commit[i] = wr_lo;

        // overflow toggle first, then the compare action on top
        always_comb begin
            next_pin = pin_q[i];
            if (overflow && ctrl[i].overflow_toggle) begin
                next_pin = ~next_pin;
            end
            if (match) begin
                next_pin = match_action(ctrl[i], next_pin);
            end
        end

        // control bits, event flag, pin state and capture pipeline
        always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
                ctrl[i]     <= '0;
                evt[i]      <= 1'b0;
                armed[i]    <= 1'b0;
                pin_q[i]    <= 1'b0;
                pin_prev[i] <= 1'b0;
                hi_wr[i]    <= 8'h00;
                lo_lat[i]   <= 8'h00;
                locked[i]   <= 1'b0;
                cap_pipe[i] <= '{default: '0};
            end else begin
                pin_prev[i] <= pin_in;
                // snapshot of the count travels with the edge
                cap_pipe[i][0] <= '{hit: hit, count: count};
                for (int s = 1; s < TCC_CAPTURE_LAT - 1; s++) begin
                    cap_pipe[i][s] <= cap_pipe[i][s-1];
                end
                if (wr_ctrl) begin
                    // channel 1 has no pair link bit
                    ctrl[i] <= (i == 1) ? (bus_wdata[6:0] & 7'h5F) : bus_wdata[6:0];
                end
                if (evt_set) begin
                    evt[i] <= 1'b1;
                end else if (wr_ctrl && armed[i] && !bus_wdata[TCC_BIT_EVT_FLAG]) begin
                    evt[i] <= 1'b0;
                end
                if (rd_ctrl && evt[i]) begin
                    armed[i] <= 1'b1;
                end else if (wr_ctrl || !evt[i]) begin
                    armed[i] <= 1'b0;
                end
                pin_q[i] <= cmp ? next_pin : 1'b0;
                if (wr_hi) begin
                    hi_wr[i] <= bus_wdata;
                end
                if (rd_hi) begin
                    lo_lat[i] <= value[i][7:0];
                    locked[i] <= 1'b1;
                end else if (rd_lo) begin
                    locked[i] <= 1'b0;
                end
            end
        end

        // value registers carry no reset so captured times survive it
        always_ff @(posedge clk_sys) begin
            if (landed) begin
                // every qualifying edge lands, overwriting older data
                value[i] <= cap_pipe[i][TCC_CAPTURE_LAT-2].count;
            end else if (wr_lo) begin
                value[i] <= {hi_wr[i], bus_wdata};
            end
        end

        assign chan_irq[i]     = evt[i] && ctrl[i].irq_enable && !idle;
        assign chan_rd_ctrl[i] = {evt[i], ctrl[i]};
        assign chan_rd_hi[i]   = value[i][15:8];
        assign chan_rd_lo[i]   = locked[i] ? lo_lat[i] : value[i][7:0];
        // full duty forces the output high for a 100 percent pulse
        assign chan_drive[i]   = (pin_q[i] | ctrl[i].full_duty) && cmp;
    end : g_chan

    // ---------------- pins and interrupt ----------------
    // a compare channel drives its pin; capture and idle release it
    assign chan0_pin_out  = chan_drive[0];
    assign chan0_pin_oe_n = !is_compare(ctrl[0]);
    assign chan1_pin_out  = chan_drive[1];
    assign chan1_pin_oe_n = !(is_compare(ctrl[1]) && !linked);
    assign irq_req        = (ovf_flag && ovf_ie) || (|chan_irq);

    // ---------------- read mux ----------------
    logic [7:0] next_rdata;

    // the read path only samples state, so counting runs on undisturbed
    always_comb begin
        unique case (bus_addr)
            TCC_ADDR_STATUS:  next_rdata = {ovf_flag, ovf_ie, halt, 2'b00, div_sel};
            TCC_ADDR_CNT_HI:  next_rdata = count[15:8];
            TCC_ADDR_CNT_LO:  next_rdata = cnt_locked ? cnt_lo_latch : count[7:0];
            TCC_ADDR_MOD_HI:  next_rdata = modulo[15:8];
            TCC_ADDR_MOD_LO:  next_rdata = modulo[7:0];
            TCC_ADDR_C0_CTRL: next_rdata = chan_rd_ctrl[0];
            TCC_ADDR_C0_HI:   next_rdata = chan_rd_hi[0];
            TCC_ADDR_C0_LO:   next_rdata = chan_rd_lo[0];
            TCC_ADDR_C1_CTRL: next_rdata = chan_rd_ctrl[1];
            TCC_ADDR_C1_HI:   next_rdata = chan_rd_hi[1];
            TCC_ADDR_C1_LO:   next_rdata = chan_rd_lo[1];
            default:          next_rdata = TCC_UNMAPPED;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata <= 8'h00;
        end else begin
            bus_rdata <= bus_rd ? next_rdata : 8'h00;
        end
    end

endmodule // tcc_timer

`default_nettype wire

/* File: verification/tcc_timer_checker.sv */
// port-level assertions for the capture/compare timer
`default_nettype none
module tcc_timer_checker
    import tcc_pkg::*;
(
    input wire logic        clk_sys,        // bus clock
    input wire logic        sys_rst,        // async reset, active high
    input wire logic [15:0] bus_addr,       // register address
    input wire logic        bus_wr,         // write strobe
    input wire logic        bus_rd,         // read strobe
    input wire logic [7:0]  bus_rdata,      // read data
    input wire logic        chan0_pin_out,  // channel 0 drive value
    input wire logic        chan0_pin_oe_n, // channel 0 enable, low drives
    input wire logic        chan1_pin_out,  // channel 1 drive value
    input wire logic        chan1_pin_oe_n, // channel 1 enable, low drives
    input wire logic        irq_req         // interrupt request
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // address falls inside the register block
    wire mapped = (bus_addr >= TCC_ADDR_STATUS) && (bus_addr <= TCC_ADDR_C1_LO);

    a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data not idle");
    a_unmapped_zero: assert property (bus_rd && !mapped |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_status_rsvd: assert property (bus_rd && bus_addr == TCC_ADDR_STATUS |=>
        bus_rdata[4:3] == 2'h0) else $error("status clear bit not reading zero");
    a_link_bit_ch1: assert property (bus_rd && bus_addr == TCC_ADDR_C1_CTRL |=>
        !bus_rdata[5]) else $error("channel 1 link bit not zero");
    // pin enables only move on a control write, never on their own
    a_oe0_cause: assert property ($changed(chan0_pin_oe_n) |->
        $past(bus_wr && bus_addr == TCC_ADDR_C0_CTRL)) else $error("ch0 enable moved");
    a_oe1_cause: assert property ($changed(chan1_pin_oe_n) |-> $past(bus_wr &&
        (bus_addr == TCC_ADDR_C0_CTRL || bus_addr == TCC_ADDR_C1_CTRL)))
        else $error("ch1 enable moved");
    a_out_gated: assert property (chan0_pin_oe_n |-> !chan0_pin_out)
        else $error("ch0 drive value outside compare mode");
    a_irq_fall: assert property ($fell(irq_req) |-> $past(bus_wr))
        else $error("interrupt dropped without a write");
    a_rst_quiet: assert property ($fell(sys_rst) |->
        !irq_req && chan0_pin_oe_n && chan1_pin_oe_n) else $error("outputs busy after reset");

    c_irq_seen: cover property ($rose(irq_req));
    c_ch1_drive: cover property (!chan1_pin_oe_n && chan1_pin_out);
    c_read_data: cover property ($past(bus_rd) && bus_rdata != 8'h00);
endmodule // tcc_timer_checker
`default_nettype wire

/* File: verification/tcc_pin_model.sv */
// pin-side model: external count clock and outside drivers of the channel pins
`default_nettype none
module tcc_pin_model (
    input  wire logic clk_sys,   // bus clock
    input  wire logic lvl0,      // outside level on channel 0
    input  wire logic lvl1,      // outside level on channel 1
    input  wire logic pin0_out,  // timer drive value, channel 0
    input  wire logic pin0_oe_n, // low while the timer drives channel 0
    input  wire logic pin1_out,  // timer drive value, channel 1
    input  wire logic pin1_oe_n, // low while the timer drives channel 1
    output logic      ext_pin,   // external count clock
    output logic      pin0_in,   // resolved channel 0 wire
    output logic      pin1_in    // resolved channel 1 wire
);
    timeunit 1ns;
    timeprecision 1ns;
    // the clock stands still low between pulses
    initial ext_pin = 1'b0;
    // a driven pin shows the timer value, a released one the outside level
    assign pin0_in = pin0_oe_n ? lvl0 : pin0_out;
    assign pin1_in = pin1_oe_n ? lvl1 : pin1_out;
    // one slow period, well under the pin rate limit; settles before return
    task automatic pulse();
        repeat (2) @(posedge clk_sys);
        ext_pin <= 1'b1;
        repeat (2) @(posedge clk_sys);
        ext_pin <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
endmodule // tcc_pin_model
`default_nettype wire

/* File: verification/tcc_timer_tb_top.sv */
// self-checking bench for the capture/compare timer
`default_nettype none
module tcc_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import tcc_pkg::*;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
    logic [15:0] bus_addr = 16'h0000, cnt = 16'h0000, exp_v;
    logic [7:0]  bus_wdata = 8'h00, bus_rdata, rdata;
    logic        lvl0 = 1'b0, lvl1 = 1'b0, exp_pin = 1'b0;
    logic        ext, c0_in, c0_out, c0_oe_n, c1_in, c1_out, c1_oe_n, irq_req;
    logic [31:0] seed = 32'h363FEF98;
    // edge code, new pin level, capture expected
    logic [3:0]  steps [6] = '{4'h7, 4'h4, 4'hA, 4'h9, 4'hF, 4'hD};
    int          fails = 0, check_count = 0, cyc = 0;

    always #50 clk_sys = ~clk_sys;
    tcc_timer i_tcc_timer (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .ext_timer_clock_pin(ext), .chan0_pin_in(c0_in), .chan0_pin_out(c0_out),
        .chan0_pin_oe_n(c0_oe_n), .chan1_pin_in(c1_in), .chan1_pin_out(c1_out),
        .chan1_pin_oe_n(c1_oe_n), .irq_req(irq_req));
    tcc_pin_model i_tcc_pin_model (.clk_sys(clk_sys), .lvl0(lvl0), .lvl1(lvl1),
        .pin0_out(c0_out), .pin0_oe_n(c0_oe_n), .pin1_out(c1_out), .pin1_oe_n(c1_oe_n),
        .ext_pin(ext), .pin0_in(c0_in), .pin1_in(c1_in));

    // xorshift step for repeatable random register data
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle write; returns after the edge has landed
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        #1;
    endtask
    task automatic wr16(input logic [15:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 16'h1, v[7:0]);
    endtask
    // read strobe one cycle, data taken in the cycle after only
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 rdata = bus_rdata;
        chk(rdata, e);
    endtask
    task automatic tick();
        i_tcc_pin_model.pulse();
        cnt++;
    endtask
    task automatic summarize();
        if (fails == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // hang guard, far above the expected run length
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdc(TCC_ADDR_STATUS, 8'h20);
        rdc(TCC_ADDR_MOD_LO, 8'hFF);
        rdc(TCC_ADDR_C1_CTRL, 8'h00);
        rdc(16'h004B, 8'h00);
        wr(TCC_ADDR_CNT_HI, 8'h5A);
        rdc(TCC_ADDR_CNT_HI, 8'h00);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr16(TCC_ADDR_MOD_HI, seed[15:0]);
            wr16(TCC_ADDR_C1_HI, seed[31:16]);
            rdc(TCC_ADDR_MOD_HI, seed[15:8]);
            rdc(TCC_ADDR_MOD_LO, seed[7:0]);
            rdc(TCC_ADDR_C1_HI, seed[31:24]);
            rdc(TCC_ADDR_C1_LO, seed[23:16]);
        end
        // short modulo at full rate, then flag handling while halted
        wr16(TCC_ADDR_MOD_HI, 16'h00FF);
        wr(TCC_ADDR_STATUS, 8'h10);
        repeat (300) @(posedge clk_sys);
        rdc(TCC_ADDR_CNT_HI, 8'h00);
        wr(TCC_ADDR_STATUS, 8'h60);
        chk({7'h0, irq_req}, 8'h01);
        rdc(TCC_ADDR_STATUS, 8'hE0);
        wr(TCC_ADDR_STATUS, 8'hE0);
        rdc(TCC_ADDR_STATUS, 8'hE0);
        wr(TCC_ADDR_STATUS, 8'h60);
        rdc(TCC_ADDR_STATUS, 8'h60);
        chk({7'h0, irq_req}, 8'h00);
        // count from the pin so every count is known
        wr16(TCC_ADDR_MOD_HI, 16'hFFFF);
        wr(TCC_ADDR_STATUS, 8'h17);
        cnt = 16'h0000;
        tick();
        tick();
        rdc(TCC_ADDR_CNT_HI, 8'h00);
        rdc(TCC_ADDR_CNT_LO, 8'h02);
        seed = xs(seed);
        exp_v = seed[15:0];
        wr16(TCC_ADDR_C0_HI, exp_v);
        for (int i = 0; i < 6; i++) begin
            wr(TCC_ADDR_C0_CTRL, {4'h4, steps[i][3:2], 2'h0});
            tick();
            @(posedge clk_sys) lvl0 <= steps[i][1];
            repeat (4) @(posedge clk_sys);
            if (steps[i][0]) exp_v = cnt;
            rdc(TCC_ADDR_C0_HI, exp_v[15:8]);
            rdc(TCC_ADDR_C0_LO, exp_v[7:0]);
        end
        rdc(TCC_ADDR_C0_CTRL, 8'hCC);
        chk({7'h0, irq_req}, 8'h01);
        // linked pair with full duty: channel 0 drives a steady high
        wr(TCC_ADDR_C0_CTRL, 8'h21);
        wr(TCC_ADDR_C1_CTRL, 8'h3C);
        rdc(TCC_ADDR_C1_CTRL, 8'h1C);
        chk({7'h0, c1_oe_n}, 8'h01);
        chk({7'h0, c0_oe_n}, 8'h00);
        chk({7'h0, c0_out}, 8'h01);
        wr(TCC_ADDR_C0_CTRL, 8'h00);
        chk({7'h0, c1_oe_n}, 8'h00);
        // set, clear, toggle on the next count
        for (int i = 3; i > 0; i--) begin
            wr16(TCC_ADDR_C1_HI, cnt + 16'h1);
            wr(TCC_ADDR_C1_CTRL, {4'h1, i[1:0], 2'h0});
            tick();
            exp_pin = (i == 1) ? ~exp_pin : i[0];
            chk({7'h0, c1_out}, {7'h0, exp_pin});
        end
        wr(TCC_ADDR_C1_CTRL, 8'h12);
        wr16(TCC_ADDR_MOD_HI, cnt + 16'h1);
        tick();
        tick();
        chk({7'h0, c1_out}, {7'h0, ~exp_pin});
        rdc(TCC_ADDR_CNT_HI, 8'h00);
        rdc(TCC_ADDR_CNT_LO, 8'h00);
        rdc(TCC_ADDR_STATUS, 8'h87);
        @(posedge clk_sys) sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdc(TCC_ADDR_C0_HI, exp_v[15:8]);
        rdc(TCC_ADDR_C0_LO, exp_v[7:0]);
        summarize();
    end
endmodule // tcc_timer_tb_top

bind tcc_timer tcc_timer_checker i_tcc_timer_checker (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .chan0_pin_out(chan0_pin_out), .chan0_pin_oe_n(chan0_pin_oe_n),
    .chan1_pin_out(chan1_pin_out), .chan1_pin_oe_n(chan1_pin_oe_n), .irq_req(irq_req));
`default_nettype wire
